// [lsdd_pkg.sv]
// Purpose: shared constants and types for the low-side driver diagnosis block
// Assumes: 10 MHz clock, 32-bit Avalon-MM register bus, word addressing by byte offset
// Notes:   nine channels: 0..4 injector, 5..6 heater, 7..8 low current
package lsdd_pkg;
    // ****************************************
    // channel layout
    // ****************************************
    localparam int N_CH       = 9;
    localparam int N_INJ      = 5;
    localparam int N_HEAT     = 2;
    localparam int N_LC       = 2;
    localparam int HEAT_FIRST = 5;
    localparam int LC_FIRST   = 7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ           = 10;
    localparam int OVC_INJ_NS        = 3000;
    localparam int OVC_HEAT_NS       = 2000;
    localparam int OVC_LC_NS         = 4000;
    localparam int DIAG_INJ_NS       = 50000;
    localparam int DIAG_HEAT_NS      = 10000;
    localparam int MASK_NS           = 400000;
    localparam int OVC_INJ_CYC       = (OVC_INJ_NS * CLK_MHZ + 999) / 1000;
    localparam int OVC_HEAT_CYC      = (OVC_HEAT_NS * CLK_MHZ + 999) / 1000;
    localparam int OVC_LC_CYC        = (OVC_LC_NS * CLK_MHZ + 999) / 1000;
    localparam int DIAG_INJ_CYC      = (DIAG_INJ_NS * CLK_MHZ + 999) / 1000;
    localparam int DIAG_HEAT_CYC     = (DIAG_HEAT_NS * CLK_MHZ + 999) / 1000;
    localparam int MASK_CYC          = (MASK_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W             = 13;

    // ****************************************
    // register map (byte offsets)
    // ****************************************
    localparam logic [3:0] ADDR_CMD    = 4'h0;
    localparam logic [3:0] ADDR_CTRL   = 4'h4;
    localparam logic [3:0] ADDR_DIAG   = 4'h8;
    localparam logic [3:0] ADDR_STATE  = 4'hc;
    localparam logic [3:0] ADDR_IRQST  = 4'h0;
    localparam logic [3:0] ADDR_IRQMSK = 4'h4;
    localparam logic [4:0] OFS_CMD     = 5'h00;
    localparam logic [4:0] OFS_CTRL    = 5'h04;
    localparam logic [4:0] OFS_DIAG    = 5'h08;
    localparam logic [4:0] OFS_STATE   = 5'h0c;
    localparam logic [4:0] OFS_IRQST   = 5'h10;
    localparam logic [4:0] OFS_IRQMSK  = 5'h14;
    localparam int CTRL_OUTDIS_BIT    = 0;
    localparam int CTRL_OFFDIAG_BIT   = 1;
    localparam int CTRL_LOWRES_BIT    = 2;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // ****************************************
    // fault codes
    // ****************************************
    localparam logic [1:0] CODE_OK  = 2'h3;
    localparam logic [1:0] CODE_OL  = 2'h1;
    localparam logic [1:0] CODE_OVC = 2'h2;
    localparam logic [1:0] CODE_SCG = 2'h0;

    typedef enum logic [1:0] {
        LSDD_IDLE,
        LSDD_ANSWER
    } lsdd_bus_state_type;

    typedef struct packed {
        logic [N_CH-1:0] ovc;
        logic [N_CH-1:0] open_load;
        logic [N_CH-1:0] short_gnd;
    } lsdd_sense_type;

    typedef struct packed {
        logic [N_CH-1:0] on;
        logic [N_CH-1:0] fast_off;
    } lsdd_drive_type;
endpackage

// [lsdd_chan.sv]
// Purpose: one low-side channel: overcurrent filter, shutdown, off-state diagnosis, fault latch
// Assumes: sense inputs already synchronised; diag_read is a one-cycle pulse
// Notes:   filter lengths come from the parent per channel type, the mask length is one value for all channels
`timescale 1ns/100ps
module lsdd_chan #(
    parameter logic [12:0] OVC_CYC  = 13'h1e,
    parameter logic [12:0] DIAG_CYC = 13'h1f4,
    parameter logic [12:0] MASK_CYC = 13'hfa0,
    parameter bit          FORCE_OK = 1'b1
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // control
    input  wire logic       i_cmd,
    input  wire logic       i_force_off,
    input  wire logic       i_diag_off,
    input  wire logic       i_diag_read,
    // sense
    input  wire logic       i_ovc,
    input  wire logic       i_ol,
    input  wire logic       i_scg,
    // results
    output logic            o_on,
    output logic            o_fast_off,
    output logic [1:0]      o_code,
    output logic            o_event
);
    import lsdd_pkg::*;

    typedef struct packed {
        logic [12:0] ovc_cnt;
        logic [12:0] diag_cnt;
        logic [12:0] mask_cnt;
        logic        shut;
        logic        cmd_q;
        logic        on;
        logic        fast;
        logic [1:0]  code;
        logic        ev;
    } lsdd_ch_type;

    lsdd_ch_type s_reg;
    lsdd_ch_type s_next;
    logic        eff_cmd;
    logic        diag_cond;
    logic        fresh;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_next     = s_reg;
        s_next.ev  = 1'b0;
        fresh      = 1'b0;
        eff_cmd    = i_cmd & ~i_force_off;
        diag_cond  = (i_ol | i_scg) & ~i_diag_off;
        // diagnosis read clears latched code
        if (i_diag_read) begin
            s_next.code = CODE_OK;
        end
        // retry on read while commanded or on a fresh rising command
        if (s_reg.shut && ((i_diag_read && eff_cmd) || (eff_cmd && !s_reg.cmd_q))) begin
            s_next.shut = 1'b0;
            s_next.fast = 1'b0;
        end
        s_next.cmd_q = eff_cmd;
        // overcurrent filter only while on, restart on release
        if (s_reg.on && i_ovc) begin
            if (s_reg.ovc_cnt >= OVC_CYC - 13'h1) begin
                s_next.shut    = 1'b1;
                s_next.fast    = 1'b1;
                s_next.code    = CODE_OVC;                           // on-state fault overwrites
                s_next.ev      = 1'b1;
                s_next.ovc_cnt = 13'h0;
            end else begin
                s_next.ovc_cnt = s_reg.ovc_cnt + 13'h1;
            end
        end else begin
            s_next.ovc_cnt = 13'h0;
        end
        s_next.on = eff_cmd & ~s_next.shut;
        if (eff_cmd) begin
            s_next.fast = s_next.shut;
        end
        // mask after switch-off
        if (s_reg.on && !s_next.on) begin
            s_next.mask_cnt = MASK_CYC;
        end else if (s_reg.mask_cnt != 13'h0) begin
            s_next.mask_cnt = s_reg.mask_cnt - 13'h1;
        end
        // off-state diagnosis filter
        if (!s_reg.on && !eff_cmd && s_reg.mask_cnt == 13'h0 && diag_cond && !FORCE_OK) begin
            if (s_reg.diag_cnt >= DIAG_CYC - 13'h1) begin
                s_next.diag_cnt = s_reg.diag_cnt;
                fresh           = 1'b1;
            end else begin
                s_next.diag_cnt = s_reg.diag_cnt + 13'h1;
            end
        end else begin
            s_next.diag_cnt = 13'h0;
        end
        // first off-state fault stays latched
        if (fresh && s_next.code == CODE_OK && !s_next.ev) begin
            s_next.code = i_scg ? CODE_SCG : CODE_OL;
            s_next.ev   = 1'b1;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '{ovc_cnt: 13'h0, diag_cnt: 13'h0, mask_cnt: 13'h0, shut: 1'b0, cmd_q: 1'b0,
                       on: 1'b0, fast: 1'b0, code: CODE_OK, ev: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_on       = s_reg.on;
    assign o_fast_off = s_reg.fast;
    assign o_code     = s_reg.code;
    assign o_event    = s_reg.ev;
endmodule

// [lsdd_top.sv]
// Purpose: nine-channel low-side driver control and diagnosis with Avalon-MM registers
// Assumes: sense inputs arrive asynchronously from the analog comparators
// Notes:   each channel is an instance of lsdd_chan
// Operation
// - five injector, two heater, two low-current channels
// - channel state follows serial command
// - reset or disable forces injector, low-current off
// - confirmed overcurrent switches off with fast slope
// - overcurrent confirmed after filter time
// - off-state open-load/short-ground filtered
// - off-state diagnosis masked after switch-off
// - disable bit blocks low-current off-state diagnosis
// - two-bit fault code per channel
// - diagnosis read clears latched codes
// - first off fault kept, on fault overwrites
// - overcurrent shutdown retried on edge or read
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
module lsdd_top (
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    // avalon-mm slave
    input  wire logic [4:0]              i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    output logic      [31:0]             o_avs_readdata,
    output logic                         o_avs_waitrequest,
    // global output reset pin
    input  wire logic                    i_global_output_reset,
    // analog sense comparators
    input  wire lsdd_pkg::lsdd_sense_type i_sense,
    // driver controls
    output lsdd_pkg::lsdd_drive_type     o_drive,
    output logic                         o_low_resistance_enable,
    // interrupt
    output logic                         o_irq
);
    import lsdd_pkg::*;

    typedef struct packed {
        lsdd_bus_state_type bst;
        logic [31:0]        rdata;
        logic               wait_n;
        logic [N_CH-1:0]    cmd;
        logic               output_disable_bit;
        logic               offstate_diag_disable;
        logic               low_resistance_enable;
        logic [N_CH-1:0]    irq_st;
        logic [N_CH-1:0]    irq_msk;
        logic               irq;
        lsdd_drive_type     drive;
        lsdd_sense_type     s1;
        lsdd_sense_type     s2;
        logic               gr1;
        logic               gr2;
    } lsdd_top_type;

    lsdd_top_type        t_reg;
    lsdd_top_type        t_next;
    logic [N_CH-1:0]     ch_on;
    logic [N_CH-1:0]     ch_fast;
    logic [N_CH-1:0]     ch_ev;
    logic [2*N_CH-1:0]   codes;
    logic [N_CH-1:0]     rd_clear;
    logic [N_CH-1:0]     force_off;
    logic                diag_take;   // diagnosis read taken on this edge

    // channel group of an index: 0 injector, 1 heater, 2 low current
    function automatic logic [1:0] ch_group(input int idx);
        if (idx >= LC_FIRST) begin
            ch_group = 2'h2;
        end else if (idx >= HEAT_FIRST) begin
            ch_group = 2'h1;
        end else begin
            ch_group = 2'h0;
        end
    endfunction

    // ****************************************
    // channels
    // ****************************************
    // nine independent channel instances
    generate
        for (genvar g = 0; g < N_CH; g++) begin : g_ch
            localparam logic [1:0]  GRP = ch_group(g);
            localparam logic [12:0] OVC = (GRP == 2'h0) ? 13'(OVC_INJ_CYC) :
                                          (GRP == 2'h1) ? 13'(OVC_HEAT_CYC) : 13'(OVC_LC_CYC);
            localparam logic [12:0] DG  = (GRP == 2'h1) ? 13'(DIAG_HEAT_CYC) : 13'(DIAG_INJ_CYC);
            // heaters not forced off by the global reset or disable
            assign force_off[g] = (GRP != 2'h1) & (t_reg.gr2 | t_reg.output_disable_bit);
            lsdd_chan #(
                .OVC_CYC  (OVC),
                .DIAG_CYC (DG),
                .MASK_CYC (13'(MASK_CYC)),
                .FORCE_OK (1'b0)
            ) u_ch (
                .i_clk       (i_clk),
                .i_rst_n     (i_rst_n),
                .i_cmd       (t_reg.cmd[g]),
                .i_force_off (force_off[g]),
                .i_diag_off  ((GRP == 2'h2) & t_reg.offstate_diag_disable),
                .i_diag_read (diag_take),
                .i_ovc       (t_reg.s2.ovc[g]),
                .i_ol        (t_reg.s2.open_load[g]),
                .i_scg       (t_reg.s2.short_gnd[g]),
                .o_on        (ch_on[g]),
                .o_fast_off  (ch_fast[g]),
                .o_code      (codes[2*g+1:2*g]),
                .o_event     (ch_ev[g])
            );
        end
    endgenerate

    // ****************************************
    // bus slave, synchronisers, interrupts
    // ****************************************
    always_comb begin
        t_next           = t_reg;
        rd_clear         = '0;
        t_next.s1        = i_sense;
        t_next.s2        = t_reg.s1;
        t_next.gr1       = i_global_output_reset;
        t_next.gr2       = t_reg.gr1;
        diag_take        = 1'b0;
        t_next.drive.on       = ch_on;
        t_next.drive.fast_off = ch_fast;
        case (t_reg.bst)
            LSDD_IDLE: begin
                t_next.wait_n = 1'b0;
                if (i_avs_read || i_avs_write) begin
                    t_next.bst    = LSDD_ANSWER;
                    t_next.wait_n = 1'b1;
                    t_next.rdata  = UNMAPPED_DATA;
                    if (i_avs_write) begin
                        case (i_avs_address)
                            OFS_CMD:    t_next.cmd = i_avs_writedata[N_CH-1:0];
                            OFS_CTRL: begin
                                t_next.output_disable_bit    = i_avs_writedata[CTRL_OUTDIS_BIT];
                                t_next.offstate_diag_disable = i_avs_writedata[CTRL_OFFDIAG_BIT];
                                t_next.low_resistance_enable = i_avs_writedata[CTRL_LOWRES_BIT];
                            end
                            OFS_IRQMSK: t_next.irq_msk = i_avs_writedata[N_CH-1:0];
                            default:    t_next.rdata = UNMAPPED_DATA;
                        endcase
                    end else begin
                        case (i_avs_address)
                            OFS_CMD:    t_next.rdata = 32'(t_reg.cmd);
                            OFS_CTRL:   t_next.rdata = {29'h0, t_reg.low_resistance_enable,
                                                        t_reg.offstate_diag_disable, t_reg.output_disable_bit};
                            OFS_DIAG: begin
                                t_next.rdata     = 32'(codes);
                                // clear on the edge that captures, so a fault latched there is not lost
                                diag_take        = 1'b1;
                            end
                            OFS_STATE:  t_next.rdata = {14'h0, ch_fast, ch_on};
                            OFS_IRQST: begin
                                t_next.rdata = 32'(t_reg.irq_st);
                                rd_clear     = '1;
                            end
                            OFS_IRQMSK: t_next.rdata = 32'(t_reg.irq_msk);
                            default:    t_next.rdata = UNMAPPED_DATA;
                        endcase
                    end
                end
            end
            LSDD_ANSWER: begin
                t_next.bst    = LSDD_IDLE;
                t_next.wait_n = 1'b0;
            end
            default: begin
                t_next.bst    = LSDD_IDLE;
                t_next.wait_n = 1'b0;
            end
        endcase
        // sticky status: a new event wins over the read clear
        t_next.irq_st = (t_reg.irq_st & ~rd_clear) | ch_ev;
        t_next.irq    = |(t_next.irq_st & t_reg.irq_msk);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    // outputs straight from flip-flops, waitrequest through an inverter on wait_n
    assign o_avs_readdata          = t_reg.rdata;
    assign o_avs_waitrequest       = ~t_reg.wait_n;
    assign o_drive                 = t_reg.drive;
    assign o_low_resistance_enable = t_reg.low_resistance_enable;
    assign o_irq                   = t_reg.irq;
endmodule

// [lsdd_top_asserts.sv]
// Purpose: port checks for the low-side driver diagnosis block
// Assumes: single clock, asynchronous active-low reset
// Notes:   bound to every lsdd_top instance
`timescale 1ns/100ps
module lsdd_top_asserts (
    // clock and reset
    input wire logic                     i_clk,
    input wire logic                     i_rst_n,
    // register bus
    input wire logic [4:0]               i_avs_address,
    input wire logic                     i_avs_read,
    input wire logic                     i_avs_write,
    input wire logic [31:0]              i_avs_writedata,
    input wire logic [31:0]              o_avs_readdata,
    input wire logic                     o_avs_waitrequest,
    // pins
    input wire logic                     i_global_output_reset,
    input wire lsdd_pkg::lsdd_sense_type i_sense,
    input wire lsdd_pkg::lsdd_drive_type o_drive,
    input wire logic                     o_low_resistance_enable,
    input wire logic                     o_irq
);
    import lsdd_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ********************
    // properties
    // ********************
    // accepted write of the control word
    sequence s_ctrl_write; i_avs_write && i_avs_address == OFS_CTRL && !o_avs_waitrequest; endsequence
    // quiet bus, long enough for any read clear to have landed
    sequence s_quiet; (!i_avs_read && !i_avs_write) [*8]; endsequence
    property p_force_off; i_global_output_reset [*6] |-> (o_drive.on & 9'h19f) == 9'h000; endproperty
    property p_fast_excl; (o_drive.fast_off & o_drive.on) == 9'h000; endproperty
    property p_ovc_inj; $rose(o_drive.fast_off[0]) |-> $past(i_sense.ovc[0], 6) && $past(i_sense.ovc[0], 25); endproperty
    property p_ovc_heat; $rose(o_drive.fast_off[5]) |-> $past(i_sense.ovc[5], 6) && $past(i_sense.ovc[5], 16); endproperty
    property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
    property p_wait_cause; !o_avs_waitrequest |-> $past(i_avs_read) || $past(i_avs_write); endproperty
    property p_unmapped; !o_avs_waitrequest && i_avs_read && (i_avs_address > 5'h14 || i_avs_address[1:0] != 2'h0)
        |-> o_avs_readdata == UNMAPPED_DATA; endproperty
    property p_low_res; s_ctrl_write |=> o_low_resistance_enable == $past(i_avs_writedata[2]); endproperty
    property p_irq_hold; s_quiet |-> o_irq || !$past(o_irq, 3); endproperty
    // assertions
    a_force_off: assert property (p_force_off) else $error("channel on while forced off");
    a_fast_excl: assert property (p_fast_excl) else $error("fast off while on");
    a_ovc_inj: assert property (p_ovc_inj) else $error("injector tripped early");
    a_ovc_heat: assert property (p_ovc_heat) else $error("heater tripped early");
    a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_low_res: assert property (p_low_res) else $error("low resistance enable wrong");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without access");
endmodule

bind lsdd_top lsdd_top_asserts chk_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_global_output_reset(i_global_output_reset),
    .i_sense(i_sense), .o_drive(o_drive), .o_low_resistance_enable(o_low_resistance_enable), .o_irq(o_irq)
);

// [lsdd_load.sv]
// Purpose: load model on the driver side, turns bench faults into comparator levels
// Assumes: faults are levels set by the bench
// Notes:   a short to ground hides an open load
`timescale 1ns/100ps
module lsdd_load (
    // driver state from the block
    input  wire lsdd_pkg::lsdd_drive_type i_drive,
    // faults set by the bench
    input  wire logic [8:0]               i_short_bat,
    input  wire logic [8:0]               i_open,
    input  wire logic [8:0]               i_short_gnd,
    // comparator outputs
    output lsdd_pkg::lsdd_sense_type      o_sense
);
    import lsdd_pkg::*;
    // current only flows while on, off-state levels only exist while off
    assign o_sense.ovc       = i_drive.on & i_short_bat;
    assign o_sense.open_load = ~i_drive.on & i_open & ~i_short_gnd;
    assign o_sense.short_gnd = ~i_drive.on & i_short_gnd;
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the low-side driver diagnosis block
// Assumes: 10 MHz clock, load model on the driver side
// Notes:   tests are register access sequences with expected values
`timescale 1ns/100ps
module testbench;
    import lsdd_pkg::*;
    // ********************
    // signals and instances
    // ********************
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    logic [4:0]     adr = 5'h00;
    logic           rd_en = 1'b0;
    logic           wr_en = 1'b0;
    logic [31:0]    wdat = 32'h0;
    logic [31:0]    rdat;
    logic           wreq;
    logic           gor = 1'b0;
    logic [8:0]     bat = 9'h000;
    logic [8:0]     opn = 9'h000;
    logic [8:0]     gnd = 9'h000;
    logic           low_res;
    logic           irq;
    lsdd_sense_type sense;
    lsdd_drive_type drive;
    logic [31:0]    seen;
    int             errors = 0;
    int             check_count = 0;
    logic [4:0]     adrs [7] = '{OFS_CMD, OFS_CTRL, OFS_DIAG, OFS_STATE, OFS_IRQST, OFS_IRQMSK, 5'h18};
    logic [31:0]    rvals [7] = '{32'h0, 32'h0, 32'h3ffff, 32'h0, 32'h0, 32'h0, 32'h0};

    lsdd_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_global_output_reset(gor), .i_sense(sense), .o_drive(drive), .o_low_resistance_enable(low_res),
        .o_irq(irq));
    lsdd_load load_u (.i_drive(drive), .i_short_bat(bat), .i_open(opn), .i_short_gnd(gnd), .o_sense(sense));

    // 100 ns clock
    initial forever #50 clk = ~clk;

    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // compare and count
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        rd_en <= ~wr;
        wr_en <= wr;
        adr   <= a;
        wdat  <= d;
        n = 0;
        // first edge takes the request, later edges look for the answer
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        seen = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (wreq !== 1'b0) begin
            check("bus timeout", 32'h1, 32'h0);
            complete_run();
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0);
        check(name, seen, exp);
    endtask
    // wait whole cycles, ending mid-cycle where outputs are settled
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // set the load faults at a rising edge
    task automatic faults(input logic [8:0] b, input logic [8:0] o, input logic [8:0] g);
        @(posedge clk);
        bat <= b;
        opn <= o;
        gnd <= g;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(adrs[i], rvals[i], "reset value");
        bus(1'b1, 5'h18, 32'hffff_ffff);
        rd(5'h18, UNMAPPED_DATA, "unmapped");
        bus(1'b1, OFS_CTRL, 32'h4);
        rd(OFS_CTRL, 32'h4, "ctrl");
        check("low res", 32'(low_res), 32'h1);
        bus(1'b1, OFS_IRQMSK, 32'h21);
        rd(OFS_IRQMSK, 32'h21, "irq mask");
        $display("test registers done");
        bus(1'b1, OFS_CMD, 32'h1ff);
        idle(8);
        check("on", 32'(drive.on), 32'h1ff);
        rd(OFS_STATE, 32'h1ff, "state");
        bus(1'b1, OFS_CTRL, 32'h1);
        idle(8);
        check("on disabled", 32'(drive.on), 32'h60);
        bus(1'b1, OFS_CTRL, 32'h0);
        @(posedge clk);
        gor <= 1'b1;
        idle(8);
        check("on reset pin", 32'(drive.on), 32'h60);
        @(posedge clk);
        gor <= 1'b0;
        idle(8);
        check("on again", 32'(drive.on), 32'h1ff);
        $display("test commands done");
        faults(9'h001, 9'h000, 9'h000);
        idle(20);
        faults(9'h000, 9'h000, 9'h000);
        idle(5);
        faults(9'h021, 9'h000, 9'h000);
        idle(25);
        check("inj filtering", 32'(drive.on[0]), 32'h1);
        idle(20);
        check("on tripped", 32'(drive.on), 32'h1de);
        check("fast off", 32'(drive.fast_off), 32'h21);
        check("irq", 32'(irq), 32'h1);
        faults(9'h000, 9'h000, 9'h000);
        rd(OFS_IRQST, 32'h21, "irq status");
        idle(4);
        check("irq cleared", 32'(irq), 32'h0);
        rd(OFS_DIAG, 32'h3fbfe, "diag ovc");
        idle(8);
        check("on retried", 32'(drive.on), 32'h1ff);
        check("fast off gone", 32'(drive.fast_off), 32'h0);
        rd(OFS_DIAG, 32'h3ffff, "diag cleared");
        $display("test overcurrent done");
        bus(1'b1, OFS_CTRL, 32'h2);
        bus(1'b1, OFS_CMD, 32'h15d);
        faults(9'h000, 9'h002, 9'h0a0);
        idle(3000);
        rd(OFS_DIAG, 32'h3ffff, "diag masked");
        idle(1800);
        faults(9'h000, 9'h000, 9'h0a2);
        idle(600);
        rd(OFS_DIAG, 32'h3f3f7, "diag off faults");
        idle(600);
        rd(OFS_DIAG, 32'h3f3f3, "diag relatched");
        $display("test off state done");
        complete_run();
    end
endmodule
